/* common/subtract_w_from_file_consts.vh */
`ifndef SUBTRACT_W_FROM_FILE_CONSTS_VH
`define SUBTRACT_W_FROM_FILE_CONSTS_VH

// Register map, byte addresses on the 8-bit register port
`define REG_CTRL        8'h00
`define REG_WORK        8'h01
`define REG_BANK        8'h02
`define REG_STATUS      8'h03
`define REG_INDEX_LO    8'h04
`define REG_INDEX_HI    8'h05
`define REG_FILE_ADDR   8'h06
`define REG_OPSEL       8'h07
`define REG_PTR_LO      8'h08
`define REG_PTR_HI      8'h09
`define REG_MEM_DATA    8'h0A
`define REG_EXEC_COUNT  8'h0B

// Control register fields
`define CTRL_EXT_BIT    0
`define CTRL_BUSY_BIT   7

// Operand select register fields
`define OPSEL_DEST_BIT  0
`define OPSEL_ACC_BIT   1

// Status register field positions
`define ST_C_BIT        0
`define ST_DC_BIT       1
`define ST_Z_BIT        2
`define ST_OV_BIT       3
`define ST_N_BIT        4
`define ST_ARITH_MASK   8'h1F

// Reset values
`define CTRL_RST        8'h00
`define WORK_RST        8'h00
`define BANK_RST        4'h0
`define STATUS_RST      8'h00
`define INDEX_RST       12'h000
`define FILE_ADDR_RST   8'h00
`define OPSEL_RST       2'h0
`define PTR_RST         12'h000
`define COUNT_RST       8'h00

// Addressing constants
`define IDX_LIMIT       8'h5F
`define ACC_SPLIT       8'h60
`define ACC_HIGH_PAGE   4'hF
`define ACC_LOW_PAGE    4'h0

// Instruction phase states, one-hot
`define ST_IDLE         5'h01
`define ST_Q1           5'h02
`define ST_Q2           5'h04
`define ST_Q3           5'h08
`define ST_Q4           5'h10

`define BYTE_ZERO       8'h00
`define ONE_BIT         1'b1
`define ZERO_BIT        1'b0

`endif

/* hw/sub_flags_alu.v */
`timescale 1ns/10ps
`include "subtract_w_from_file_consts.vh"
module sub_flags_alu #(
	parameter W = 8
) (
	file_val,   // Minuend, file register value
	work_val,   // Subtrahend, working register value
	diff,       // Two's complement difference
	carry,      // Set when no borrow
	half_carry, // Set when no borrow out of the low nibble
	zero,       // Difference is zero
	overflow,   // Signed overflow
	negative    // Sign of the difference
);
	input  wire [W-1:0] file_val;   // Minuend
	input  wire [W-1:0] work_val;   // Subtrahend
	output wire [W-1:0] diff;       // Difference
	output wire         carry;      // No borrow
	output wire         half_carry; // No nibble borrow
	output wire         zero;       // Zero result
	output wire         overflow;   // Signed overflow
	output wire         negative;   // Result sign

	wire [W:0] full_sum;
	wire [4:0] low_sum;

	// Add the inverse plus one so carry out means no borrow
	assign full_sum   = {1'b0, file_val} + {1'b0, ~work_val} + {{W{1'b0}}, `ONE_BIT};
	assign low_sum    = {1'b0, file_val[3:0]} + {1'b0, ~work_val[3:0]} + 5'h01;
	assign diff       = full_sum[W-1:0];
	assign carry      = full_sum[W];
	assign half_carry = low_sum[4];
	assign zero       = (diff == {W{1'b0}});
	assign negative   = diff[W-1];
	assign overflow   = (file_val[W-1] ^ work_val[W-1]) & (diff[W-1] ^ file_val[W-1]);
endmodule

/* hw/subtract_w_from_file_exec.v */
`timescale 1ns/10ps
`include "subtract_w_from_file_consts.vh"
module subtract_w_from_file_exec #(
	parameter ADDR_W = 12,
	parameter BANK_W = 4
) (
	ref_clk, // Core clock
	nrst,    // Asynchronous reset, active low
	addr,    // Register port address
	wdata,   // Register port write data
	wr_en,   // Write strobe
	rd_en,   // Read strobe
	rdata,   // Read data, one cycle after the strobe
	busy,    // Instruction in progress
	done     // One-cycle pulse after the write phase
);
	input  wire        ref_clk; // Clock
	input  wire        nrst;    // Reset
	input  wire [7:0]  addr;    // Address
	input  wire [7:0]  wdata;   // Write data
	input  wire        wr_en;   // Write strobe
	input  wire        rd_en;   // Read strobe
	output reg  [7:0]  rdata;   // Read data
	output wire        busy;    // Busy level
	output reg         done;    // Done pulse

	localparam MEM_DEPTH = 1 << ADDR_W;

	reg [7:0]        mem [0:MEM_DEPTH-1];

	reg [4:0]        state_q;
	reg [4:0]        state_d;
	reg              ext_en_q;
	reg [7:0]        work_q;
	reg [BANK_W-1:0] bank_q;
	reg [7:0]        status_q;
	reg [ADDR_W-1:0] index_q;
	reg [7:0]        file_addr_q;
	reg              dest_q;
	reg              acc_q;
	reg [ADDR_W-1:0] ptr_q;
	reg [7:0]        count_q;
	reg [ADDR_W-1:0] ea_q;
	reg [ADDR_W-1:0] ea_d;
	reg [7:0]        opnd_q;
	reg [7:0]        opw_q;
	reg [7:0]        result_q;
	reg [4:0]        flags_q;
	reg [7:0]        rd_mux;

	wire [7:0]       diff;
	wire             fl_c;
	wire             fl_dc;
	wire             fl_z;
	wire             fl_ov;
	wire             fl_n;
	wire             start;
	wire             sw_wr_mem;
	wire             q4_mem;
	wire             q4_work;

	assign busy      = (state_q != `ST_IDLE);
	assign start     = wr_en & (addr == `REG_FILE_ADDR) & ~busy;
	assign sw_wr_mem = wr_en & (addr == `REG_MEM_DATA);
	assign q4_mem    = (state_q == `ST_Q4) & dest_q;
	assign q4_work   = (state_q == `ST_Q4) & ~dest_q;

	sub_flags_alu #(
		.W (8)
	) u_alu (
		.file_val   (opnd_q),
		.work_val   (opw_q),
		.diff       (diff),
		.carry      (fl_c),
		.half_carry (fl_dc),
		.zero       (fl_z),
		.overflow   (fl_ov),
		.negative   (fl_n)
	);

	// Effective address formed during decode
	always @* begin
		ea_d = {ADDR_W{1'b0}};
		if (acc_q) begin
			ea_d = {{(ADDR_W-BANK_W-8){1'b0}}, bank_q, file_addr_q};
		end else if (ext_en_q && (file_addr_q <= `IDX_LIMIT)) begin
			ea_d = index_q + {{(ADDR_W-8){1'b0}}, file_addr_q};
		end else if (file_addr_q < `ACC_SPLIT) begin
			ea_d = {{(ADDR_W-12){1'b0}}, `ACC_LOW_PAGE, file_addr_q};
		end else begin
			ea_d = {{(ADDR_W-12){1'b0}}, `ACC_HIGH_PAGE, file_addr_q};
		end
	end

	// Phase sequencer
	always @* begin
		state_d = state_q;
		case (state_q)
			`ST_IDLE: begin
				if (start) begin
					state_d = `ST_Q1;
				end
			end
			`ST_Q1: begin
				state_d = `ST_Q2;
			end
			`ST_Q2: begin
				state_d = `ST_Q3;
			end
			`ST_Q3: begin
				state_d = `ST_Q4;
			end
			`ST_Q4: begin
				state_d = `ST_IDLE;
			end
			default: begin
				state_d = `ST_IDLE;
			end
		endcase
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= `ST_IDLE;
			done    <= `ZERO_BIT;
		end else begin
			state_q <= state_d;
			done    <= (state_q == `ST_Q4);
		end
	end

	// Decode, read and process phases
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ea_q     <= {ADDR_W{1'b0}};
			opnd_q   <= `BYTE_ZERO;
			opw_q    <= `BYTE_ZERO;
			result_q <= `BYTE_ZERO;
			flags_q  <= 5'h00;
		end else begin
			if (state_q == `ST_Q1) begin
				ea_q <= ea_d;
			end
			if (state_q == `ST_Q2) begin
				opnd_q <= mem[ea_q];
				opw_q  <= work_q;
			end
			if (state_q == `ST_Q3) begin
				result_q <= diff;
				flags_q  <= {fl_n, fl_ov, fl_z, fl_dc, fl_c};
			end
		end
	end

	// Data memory, write phase has priority over software
	always @(posedge ref_clk) begin
		if (q4_mem) begin
			mem[ea_q] <= result_q;
		end else if (sw_wr_mem) begin
			mem[ptr_q] <= wdata;
		end
	end

	// Software registers and working register
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ext_en_q    <= `ZERO_BIT;
			work_q      <= `WORK_RST;
			bank_q      <= `BANK_RST;
			index_q     <= `INDEX_RST;
			file_addr_q <= `FILE_ADDR_RST;
			dest_q      <= `ZERO_BIT;
			acc_q       <= `ZERO_BIT;
			ptr_q       <= `PTR_RST;
			count_q     <= `COUNT_RST;
		end else begin
			if (wr_en) begin
				case (addr)
					`REG_CTRL: begin
						ext_en_q <= wdata[`CTRL_EXT_BIT];
					end
					`REG_WORK: begin
						work_q <= wdata;
					end
					`REG_BANK: begin
						bank_q <= wdata[BANK_W-1:0];
					end
					`REG_INDEX_LO: begin
						index_q[7:0] <= wdata;
					end
					`REG_INDEX_HI: begin
						index_q[ADDR_W-1:8] <= wdata[ADDR_W-9:0];
					end
					`REG_FILE_ADDR: begin
						if (!busy) begin
							file_addr_q <= wdata;
						end
					end
					`REG_OPSEL: begin
						if (!busy) begin
							dest_q <= wdata[`OPSEL_DEST_BIT];
							acc_q  <= wdata[`OPSEL_ACC_BIT];
						end
					end
					`REG_PTR_LO: begin
						ptr_q[7:0] <= wdata;
					end
					`REG_PTR_HI: begin
						ptr_q[ADDR_W-1:8] <= wdata[ADDR_W-9:0];
					end
					default: begin
					end
				endcase
			end
			// Instruction result wins over a software write in the same cycle
			if (q4_work) begin
				work_q <= result_q;
			end
			if (state_q == `ST_Q4) begin
				count_q <= count_q + 8'h01;
			end
		end
	end

	// Status: only the five arithmetic flags are touched by the instruction
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			status_q <= `STATUS_RST;
		end else if (state_q == `ST_Q4) begin
			status_q <= (status_q & ~`ST_ARITH_MASK) | {3'h0, flags_q};
		end else if (wr_en && (addr == `REG_STATUS)) begin
			status_q <= wdata;
		end
	end

	always @* begin
		rd_mux = `BYTE_ZERO;
		case (addr)
			`REG_CTRL: begin
				rd_mux = {busy, 6'h00, ext_en_q};
			end
			`REG_WORK: begin
				rd_mux = work_q;
			end
			`REG_BANK: begin
				rd_mux = {{(8-BANK_W){1'b0}}, bank_q};
			end
			`REG_STATUS: begin
				rd_mux = status_q;
			end
			`REG_INDEX_LO: begin
				rd_mux = index_q[7:0];
			end
			`REG_INDEX_HI: begin
				rd_mux = {{(16-ADDR_W){1'b0}}, index_q[ADDR_W-1:8]};
			end
			`REG_FILE_ADDR: begin
				rd_mux = file_addr_q;
			end
			`REG_OPSEL: begin
				rd_mux = {6'h00, acc_q, dest_q};
			end
			`REG_PTR_LO: begin
				rd_mux = ptr_q[7:0];
			end
			`REG_PTR_HI: begin
				rd_mux = {{(16-ADDR_W){1'b0}}, ptr_q[ADDR_W-1:8]};
			end
			`REG_MEM_DATA: begin
				rd_mux = mem[ptr_q];
			end
			`REG_EXEC_COUNT: begin
				rd_mux = count_q;
			end
			default: begin
				rd_mux = `BYTE_ZERO;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= `BYTE_ZERO;
		end else if (rd_en) begin
			rdata <= rd_mux;
		end else begin
			rdata <= `BYTE_ZERO;
		end
	end
endmodule

/* tb/subtract_w_from_file_exec_props.sv */
`timescale 1ns/10ps
module subtract_w_from_file_exec_props (
	input wire       ref_clk, // Clock
	input wire       nrst,    // Reset
	input wire [7:0] addr,    // Address
	input wire [7:0] wdata,   // Write data
	input wire       wr_en,   // Write strobe
	input wire       rd_en,   // Read strobe
	input wire [7:0] rdata,   // Read data
	input wire       busy,    // Busy
	input wire       done     // Done
);
	reg  [2:0] sw_q;
	reg        inst_q;
	reg  [7:0] cnt_q;
	wire       start = wr_en && addr == 8'h06;
	// Track software status bits, instruction-owned flags and executions
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sw_q <= 3'h0;
			inst_q <= 1'b0;
			cnt_q <= 8'h00;
		end else begin
			if (wr_en && addr == 8'h03) begin
				sw_q <= wdata[7:5];
				inst_q <= 1'b0;
			end else if (done) begin
				inst_q <= 1'b1;
			end
			if (done) begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_run; start && !busy |=> busy [*4] ##1 (!busy && done); endproperty
	property p_idle; !busy && !start |=> !busy; endproperty
	property p_pulse; done |=> !done; endproperty
	property p_fall; $fell(busy) |-> done; endproperty
	property p_busy_rd; rd_en && addr == 8'h00 |=> rdata[7] == $past(busy); endproperty
	property p_sw; rd_en && addr == 8'h03 |=> rdata[7:5] == sw_q; endproperty
	property p_zero; rd_en && addr == 8'h03 && inst_q |=> !rdata[2] || rdata[4:0] == 5'h07;
	endproperty
	property p_cnt; rd_en && addr == 8'h0B |=> rdata == cnt_q; endproperty
	a_run: assert property (p_run) else $error("phase sequence wrong");
	a_idle: assert property (p_idle) else $error("busy without start");
	a_pulse: assert property (p_pulse) else $error("done too long");
	a_fall: assert property (p_fall) else $error("busy ended without done");
	a_busy_rd: assert property (p_busy_rd) else $error("busy bit wrong");
	a_sw: assert property (p_sw) else $error("software status bits changed");
	a_zero: assert property (p_zero) else $error("zero flags inconsistent");
	a_cnt: assert property (p_cnt) else $error("exec count wrong");
	c_start: cover property (start && !busy);
	c_refused: cover property (start && busy);
	c_zero: cover property (rd_en && addr == 8'h03 && inst_q);
endmodule
bind subtract_w_from_file_exec subtract_w_from_file_exec_props u_props (.ref_clk(ref_clk),
	.nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
	.busy(busy), .done(done));

/* tb/test_subtract_w_from_file_exec.sv */
`timescale 1ns/10ps
module test_subtract_w_from_file_exec;
	reg         ref_clk = 1'b0;
	reg         nrst;
	reg  [7:0]  addr;
	reg  [7:0]  wdata;
	reg         wr_en;
	reg         rd_en;
	wire [7:0]  rdata;
	wire        busy;
	wire        done;
	integer     errors;
	integer     check_count;
	integer     i;
	reg  [47:0] r;
	reg  [11:0] e;
	reg  [7:0]  v;
	// Rows: {0,ext,a,d}, bank, f, file value, working value, difference, flags {N,OV,Z,DC,C}
	reg  [47:0] rows [0:7];
	subtract_w_from_file_exec dut (.ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .busy(busy), .done(done));
	always #5 ref_clk = ~ref_clk;
	function automatic [11:0] ea(input [47:0] q);
		if (q[45]) ea = q[43:32];
		else if (q[46] && q[39:32] <= 8'h5F) ea = 12'h123 + q[39:32];
		else ea = {(q[39:32] < 8'h60) ? 4'h0 : 4'hF, q[39:32]};
	endfunction
	task give_verdict;
		begin
			$display("checks %0d errors %0d", check_count, errors);
			if (errors == 0 && check_count > 0) begin
				$display("STATUS OK");
			end else begin
				$display("STATUS NOT OK");
			end
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("ERROR %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] w);
		begin
			@(posedge ref_clk);
			wr_en <= 1'b1;
			addr <= a;
			wdata <= w;
			@(posedge ref_clk);
			wr_en <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, output [7:0] q);
		begin
			@(posedge ref_clk);
			rd_en <= 1'b1;
			addr <= a;
			@(posedge ref_clk);
			rd_en <= 1'b0;
			#1 q = rdata;
		end
	endtask
	task wait_done;
		integer k;
		begin
			k = 0;
			#1;
			while (done !== 1'b1 && k < 8) begin
				@(posedge ref_clk);
				#1 k = k + 1;
			end
			if (done !== 1'b1) begin
				errors = errors + 1;
				$display("ERROR %0t: no done", $time);
				give_verdict;
			end
		end
	endtask
	initial begin
		nrst = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		errors = 0;
		check_count = 0;
		rows[0] = 48'h101003020103;
		rows[1] = 48'h002002020007;
		rows[2] = 48'h10700102FF10;
		rows[3] = 48'h353380017F09;
		rows[4] = 48'h405F10010F01;
		rows[5] = 48'h50607FFF801A;
		rows[6] = 48'h6A0500000007;
		rows[7] = 48'h50003C5AE212;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		for (i = 0; i < 12; i = i + 1) begin
			if (i != 10) begin
				rd(i[7:0], v);
				chk(v, 8'h00);
			end
		end
		rd(8'hFF, v);
		chk(v, 8'h00);
		wr(8'h04, 8'h23);
		wr(8'h05, 8'h01);
		for (i = 0; i < 8; i = i + 1) begin
			r = rows[i];
			e = ea(r);
			wr(8'h00, {7'h00, r[46]});
			wr(8'h02, {4'h0, r[43:40]});
			wr(8'h08, e[7:0]);
			wr(8'h09, {4'h0, e[11:8]});
			wr(8'h0A, r[31:24]);
			wr(8'h01, r[23:16]);
			wr(8'h03, 8'hBF);
			wr(8'h07, {6'h00, r[45], r[44]});
			wr(8'h06, r[39:32]);
			wait_done;
			rd(8'h01, v);
			chk(v, r[44] ? r[23:16] : r[15:8]);
			rd(8'h0A, v);
			chk(v, r[44] ? r[15:8] : r[31:24]);
			rd(8'h03, v);
			chk(v, {3'h5, r[4:0]});
		end
		// Start and operand select writes while busy must be ignored
		wr(8'h00, 8'h00);
		wr(8'h08, 8'h10);
		wr(8'h09, 8'h00);
		wr(8'h0A, 8'h09);
		wr(8'h01, 8'h04);
		wr(8'h07, 8'h01);
		wr(8'h06, 8'h10);
		wr(8'h07, 8'h00);
		wr(8'h06, 8'h10);
		wait_done;
		rd(8'h0A, v);
		chk(v, 8'h05);
		rd(8'h01, v);
		chk(v, 8'h04);
		rd(8'h0B, v);
		chk(v, 8'h09);
		// Reset in mid-instruction aborts it before the write phase; memory keeps its data
		wr(8'h07, 8'h01);
		wr(8'h06, 8'h10);
		@(posedge ref_clk);
		nrst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(8'h00, v);
		chk(v, 8'h00);
		rd(8'h0B, v);
		chk(v, 8'h00);
		rd(8'h01, v);
		chk(v, 8'h00);
		wr(8'h08, 8'h10);
		rd(8'h0A, v);
		chk(v, 8'h05);
		give_verdict;
	end
endmodule
